// ### verilog/uart_map.svh
/*
 * constants for the asynchronous serial transceiver: sample counts,
 * control field layout and reset levels.
 * assumes inclusion by bare name from the design files.
 */
`ifndef UART_MAP_SVH
`define UART_MAP_SVH

// ----------------------------------------------------------------------
// timing in 16x ticks
// ----------------------------------------------------------------------
`define TICKS_PER_BIT   4'hf
`define HALF_BIT        4'h7
`define TICK_CNT_ZERO   4'h0

// ----------------------------------------------------------------------
// control holding register layout
// ----------------------------------------------------------------------
`define CTL_W           5
`define CTL_SENSE       4
`define CTL_NOPAR       3
`define CTL_TWOSTOP     2
`define CTL_LEN_HI      1
`define CTL_LEN_LO      0
`define CTL_RESET       5'h00

// ----------------------------------------------------------------------
// data widths and reset levels
// ----------------------------------------------------------------------
`define DATA_W          8
`define DATA_RESET      8'h00
`define BITCNT_ZERO     3'h0
`define LEN_BASE        3'h4

`endif

// ### verilog/uart_pkg.sv
/*
 * types shared by the transceiver files.
 * assumes nothing beyond a systemverilog compiler.
 */
package uart_pkg;

	typedef enum logic [4:0] {
		st_idle   = 5'h01,
		st_start  = 5'h02,
		st_data   = 5'h04,
		st_parity = 5'h08,
		st_stop   = 5'h10
	} serial_state_t;

endpackage

// ### verilog/edge_sync.sv
/*
 * two-stage synchroniser with a falling-edge pulse on the synced level.
 * assumes one clock; input is asynchronous to mclk.
 */
`timescale 1ns/1ps

module edge_sync
#(
	parameter logic IDLE_LEVEL = 1'b1
)
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// async level in
	input  wire logic pin,
	// synchronised level and falling edge
	output logic      level,
	output logic      fall
);

	logic stage1;
	logic prev;

	// stage1 feeds only level; edge logic looks at level and prev
	always_ff @(posedge mclk or negedge nrst)
	begin
		// reset to the pin's idle level so no false edge follows reset
		if (!nrst)
		begin
			stage1 <= IDLE_LEVEL;
			level  <= IDLE_LEVEL;
			prev   <= IDLE_LEVEL;
		end
		else
		begin
			stage1 <= pin;
			level  <= stage1;
			prev   <= level;
		end
	end

	assign fall = prev & ~level;

endmodule

// ### verilog/async_serial_transceiver.sv
/*
 * double-buffered asynchronous receiver/transmitter with parallel
 * strobed loading and flag outputs.
 * assumes mclk at 100 MHz well above 16x clocks, which arrive as pins
 * and are synchronised here; strobes and data inputs also are pins.
 */
`timescale 1ns/1ps
`include "uart_map.svh"

module async_serial_transceiver
(
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               nrst,
	input  wire logic               external_reset_in,
	// 16x rate clocks from outside
	input  wire logic               tx_clock_16x,
	input  wire logic               rx_clock_16x,
	// control inputs
	input  wire logic               control_load_strobe,
	input  wire logic               parity_sense_select,
	input  wire logic               parity_disable,
	input  wire logic               stop_count_select,
	input  wire logic               length_select_lo,
	input  wire logic               length_select_hi,
	// transmit data
	input  wire logic               data_load_strobe,
	input  wire logic [`DATA_W-1:0] tx_data,
	// receive data and status
	input  wire logic               rx_data_taken,
	output logic      [`DATA_W-1:0] rx_data,
	output logic                    rx_char_ready,
	output logic                    parity_fault,
	output logic                    frame_fault,
	output logic                    overrun,
	// transmit status
	output logic                    tx_holding_empty,
	output logic                    char_end,
	// serial line
	input  wire logic               serial_in,
	output logic                    serial_out
);

	// ------------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------------
	logic xr_s, tclk_fall, rclk_fall, si_s, si_fall;
	logic cs_s, ds_s, ds_rise, rdt_fall, xr_prev;
	logic [`DATA_W-1:0] din_s1, din_s2;

	// every pin but the line idles low
	edge_sync #(.IDLE_LEVEL(1'b0)) u_xr (.mclk(mclk), .nrst(nrst),
		.pin(external_reset_in), .level(xr_s), .fall());
	edge_sync #(.IDLE_LEVEL(1'b0)) u_tclk (.mclk(mclk), .nrst(nrst),
		.pin(tx_clock_16x), .level(), .fall(tclk_fall));
	edge_sync #(.IDLE_LEVEL(1'b0)) u_rclk (.mclk(mclk), .nrst(nrst),
		.pin(rx_clock_16x), .level(), .fall(rclk_fall));
	edge_sync #(.IDLE_LEVEL(1'b1)) u_si (.mclk(mclk), .nrst(nrst),
		.pin(serial_in), .level(si_s), .fall(si_fall));
	edge_sync #(.IDLE_LEVEL(1'b0)) u_cs (.mclk(mclk), .nrst(nrst),
		.pin(control_load_strobe), .level(cs_s), .fall());
	edge_sync #(.IDLE_LEVEL(1'b0)) u_ds (.mclk(mclk), .nrst(nrst),
		.pin(data_load_strobe), .level(ds_s), .fall());
	edge_sync #(.IDLE_LEVEL(1'b0)) u_rdt (.mclk(mclk), .nrst(nrst),
		.pin(rx_data_taken), .level(), .fall(rdt_fall));

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			din_s1  <= `DATA_RESET;
			din_s2  <= `DATA_RESET;
			xr_prev <= 1'b0;
		end
		else
		begin
			din_s1  <= tx_data;
			din_s2  <= din_s1;
			xr_prev <= ds_s;
		end
	end

	// data enters on the strobe's rising edge
	assign ds_rise = ds_s & ~xr_prev;

	// ------------------------------------------------------------------
	// control holding register
	// ------------------------------------------------------------------
	logic [`CTL_W-1:0] ctl;
	logic [2:0]        data_last;
	logic              par_on, two_stop, par_odd;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			ctl <= `CTL_RESET;
		else if (xr_s)
			ctl <= `CTL_RESET;
		else if (cs_s)
			ctl <= {parity_sense_select, parity_disable, stop_count_select,
				length_select_hi, length_select_lo};
	end

	// one control set serves both directions
	assign data_last = `LEN_BASE + {1'b0, ctl[`CTL_LEN_HI],
		ctl[`CTL_LEN_LO]};
	assign par_on    = ~ctl[`CTL_NOPAR];
	assign two_stop  = ctl[`CTL_TWOSTOP];
	// sense low gives odd parity
	assign par_odd   = ~ctl[`CTL_SENSE];

	// ------------------------------------------------------------------
	// transmitter
	// ------------------------------------------------------------------
	uart_pkg::serial_state_t tx_st;
	logic [`DATA_W-1:0] hold, tx_sh;
	logic [3:0]         tx_tick;
	logic [2:0]         tx_bit;
	logic               tx_par, tx_stop2;
	logic               tx_bit_end, tx_load;

	// one tick per falling edge of the 16x clock
	assign tx_bit_end = tclk_fall && tx_tick == `TICKS_PER_BIT;
	// a fresh strobe defers the transfer a tick, so its char is kept
	assign tx_load = !tx_holding_empty && !ds_rise &&
		tx_st == uart_pkg::st_idle && tclk_fall;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			hold <= `DATA_RESET;
		else if (ds_rise)
			hold <= din_s2;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			tx_holding_empty <= 1'b1;
		else if (xr_s)
			tx_holding_empty <= 1'b1;
		else if (ds_rise)
			tx_holding_empty <= 1'b0;
		else if (tx_load)
			tx_holding_empty <= 1'b1;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_st      <= uart_pkg::st_idle;
			tx_sh      <= `DATA_RESET;
			tx_tick    <= `TICK_CNT_ZERO;
			tx_bit     <= `BITCNT_ZERO;
			tx_par     <= 1'b0;
			tx_stop2   <= 1'b0;
			serial_out <= 1'b1;
			char_end   <= 1'b1;
		end
		else if (xr_s)
		begin
			tx_st      <= uart_pkg::st_idle;
			tx_tick    <= `TICK_CNT_ZERO;
			serial_out <= 1'b1;
			char_end   <= 1'b1;
		end
		else
		begin
			if (tclk_fall && tx_st != uart_pkg::st_idle)
				tx_tick <= tx_tick + 4'h1;
			case (tx_st)
			uart_pkg::st_idle:
				if (tx_load)
				begin
					tx_sh      <= hold;
					tx_par     <= par_odd;
					tx_bit     <= `BITCNT_ZERO;
					tx_tick    <= `TICK_CNT_ZERO;
					serial_out <= 1'b0;
					char_end   <= 1'b0;
					tx_st      <= uart_pkg::st_start;
				end
			uart_pkg::st_start:
				if (tx_bit_end)
				begin
					serial_out <= tx_sh[0];
					tx_par     <= tx_par ^ tx_sh[0];
					tx_st      <= uart_pkg::st_data;
				end
			uart_pkg::st_data:
				if (tx_bit_end)
				begin
					tx_sh  <= tx_sh >> 1;
					tx_bit <= tx_bit + 3'h1;
					if (tx_bit == data_last)
					begin
						tx_stop2 <= two_stop;
						if (par_on)
						begin
							serial_out <= tx_par;
							tx_st      <= uart_pkg::st_parity;
						end
						else
						begin
							serial_out <= 1'b1;
							tx_st      <= uart_pkg::st_stop;
						end
					end
					else
					begin
						serial_out <= tx_sh[1];
						tx_par     <= tx_par ^ tx_sh[1];
					end
				end
			uart_pkg::st_parity:
				if (tx_bit_end)
				begin
					serial_out <= 1'b1;
					tx_st      <= uart_pkg::st_stop;
				end
			uart_pkg::st_stop:
				if (tx_bit_end)
				begin
					if (tx_stop2)
						tx_stop2 <= 1'b0;
					else
					begin
						char_end <= 1'b1;
						tx_st    <= uart_pkg::st_idle;
					end
				end
			default:
				tx_st <= uart_pkg::st_idle;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------------
	uart_pkg::serial_state_t rx_st;
	logic [`DATA_W-1:0] rx_sh;
	logic [3:0]         rx_tick;
	logic [2:0]         rx_bit;
	logic               rx_par, rx_armed, rx_sample, rx_done;
	logic               rx_perr, ready_clear;

	// sampling at tick 7 of each bit puts the sample mid bit
	assign rx_sample = rclk_fall && rx_tick == `HALF_BIT;
	assign rx_done = rx_st == uart_pkg::st_stop && rx_sample && !rx_armed;
	assign ready_clear = rdt_fall;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_st    <= uart_pkg::st_idle;
			rx_sh    <= `DATA_RESET;
			rx_tick  <= `TICK_CNT_ZERO;
			rx_bit   <= `BITCNT_ZERO;
			rx_par   <= 1'b0;
			rx_armed <= 1'b0;
			rx_perr  <= 1'b0;
			frame_fault <= 1'b0;
		end
		else if (xr_s)
		begin
			rx_st   <= uart_pkg::st_idle;
			rx_tick <= `TICK_CNT_ZERO;
			frame_fault <= 1'b0;
		end
		else
		begin
			if (rclk_fall && rx_st != uart_pkg::st_idle)
				rx_tick <= rx_tick + 4'h1;
			case (rx_st)
			uart_pkg::st_idle:
				// counting starts at the next clock fall, whatever its
				// level at the line fall
				if (si_fall)
				begin
					rx_tick <= `TICK_CNT_ZERO;
					rx_st   <= uart_pkg::st_start;
				end
			uart_pkg::st_start:
				if (rx_sample)
				begin
					if (si_s)
						rx_st <= uart_pkg::st_idle;
					else
					begin
						rx_bit <= `BITCNT_ZERO;
						rx_par <= par_odd;
						rx_st  <= uart_pkg::st_data;
					end
				end
			uart_pkg::st_data:
				if (rx_sample)
				begin
					rx_sh  <= {si_s, rx_sh[`DATA_W-1:1]};
					rx_par <= rx_par ^ si_s;
					rx_bit <= rx_bit + 3'h1;
					rx_armed <= two_stop;
					if (rx_bit == data_last)
						rx_st <= par_on ? uart_pkg::st_parity
							: uart_pkg::st_stop;
				end
			uart_pkg::st_parity:
				if (rx_sample)
				begin
					rx_perr <= rx_par ^ si_s;
					rx_st   <= uart_pkg::st_stop;
				end
			uart_pkg::st_stop:
				if (rx_sample)
				begin
					rx_armed <= 1'b0;
					if (!rx_armed)
					begin
						frame_fault <= ~si_s;
						rx_st       <= uart_pkg::st_idle;
					end
				end
			default:
				rx_st <= uart_pkg::st_idle;
			endcase
		end
	end

	// short chars sit right justified in the holding register
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_data       <= `DATA_RESET;
			rx_char_ready <= 1'b0;
			overrun       <= 1'b0;
			parity_fault  <= 1'b0;
		end
		else if (xr_s)
		begin
			rx_char_ready <= 1'b0;
			overrun       <= 1'b0;
			parity_fault  <= 1'b0;
		end
		else if (rx_done)
		begin
			// shifter is free again at once
			rx_data       <= rx_sh >> (3'h7 - data_last);
			rx_char_ready <= 1'b1; // set beats clear
			overrun       <= rx_char_ready;
			parity_fault  <= par_on & rx_perr;
		end
		else
		begin
			if (ready_clear)
				rx_char_ready <= 1'b0;
			if (!par_on)
				parity_fault <= 1'b0;
		end
	end

endmodule

// ### bench/async_serial_transceiver_asserts.sv
/* port checker for the serial transceiver, bound to its top module.
   assumes a 16x transmit clock of 8 mclk periods. */
`timescale 1ns/1ps
module uart_chk
(
	// clock and resets
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic external_reset_in,
	// strobes and control
	input  wire logic control_load_strobe,
	input  wire logic parity_disable,
	input  wire logic data_load_strobe,
	input  wire logic rx_data_taken,
	// status and line
	input  wire logic rx_char_ready,
	input  wire logic parity_fault,
	input  wire logic overrun,
	input  wire logic tx_holding_empty,
	input  wire logic char_end,
	input  wire logic serial_out
);
	// ----
	// helpers
	// ----
	// a bit is 128 mclk; margin covers pin sync jitter
	localparam int MIN_BIT = 120;
	logic [7:0] hold_cnt;
	logic [3:0] ext_cnt;
	logic       nopar_q;
	wire        quiet = ext_cnt == 4'hf;

	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			hold_cnt <= 8'hff;
		else if ($changed(serial_out))
			hold_cnt <= 8'h00;
		else if (hold_cnt != 8'hff)
			hold_cnt <= hold_cnt + 8'h01;

	// external reset forces levels mid-bit; skip a while after it
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			ext_cnt <= 4'hf;
		else if (external_reset_in)
			ext_cnt <= 4'h0;
		else if (!quiet)
			ext_cnt <= ext_cnt + 4'h1;

	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			nopar_q <= 1'b0;
		else if (control_load_strobe)
			nopar_q <= parity_disable;

	// ----
	// properties
	// ----
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_load;
		$rose(data_load_strobe);
	endsequence
	sequence s_full;
		##[1:8] !tx_holding_empty;
	endsequence

	a_load_clears_flag:
		assert property (s_load |-> s_full)
		else $error("holding flag stayed high after load");
	a_ext_tx_idle:
		assert property (external_reset_in [*5] |->
			serial_out && tx_holding_empty && char_end)
		else $error("transmit flags not set by external reset");
	a_ext_rx_clear:
		assert property (external_reset_in [*5] |-> !rx_char_ready)
		else $error("ready not cleared by external reset");
	a_transfer_flags:
		assert property ($fell(char_end) && quiet |->
			!serial_out && tx_holding_empty)
		else $error("transfer did not update line and flags together");
	a_char_end_late:
		assert property ($rose(char_end) && quiet |->
			serial_out && hold_cnt >= MIN_BIT)
		else $error("char end rose before a full stop bit");
	a_bit_hold_time:
		assert property ($changed(serial_out) && quiet |->
			hold_cnt >= MIN_BIT)
		else $error("serial bit shorter than sixteen ticks");
	a_parity_off:
		assert property ($rose(rx_char_ready) && nopar_q |-> !parity_fault)
		else $error("parity fault with parity disabled");
	a_overrun_cause:
		assert property ($rose(overrun) |-> $past(rx_char_ready))
		else $error("overrun without a pending character");
	a_taken_clears:
		assert property ($fell(rx_data_taken) |-> ##[1:8] !rx_char_ready)
		else $error("ready not cleared after read");
endmodule

bind async_serial_transceiver uart_chk u_chk (.mclk, .nrst,
	.external_reset_in, .control_load_strobe, .parity_disable,
	.data_load_strobe, .rx_data_taken, .rx_char_ready, .parity_fault,
	.overrun, .tx_holding_empty, .char_end, .serial_out);

// ### bench/serial_terminal.sv
/* remote sender model driving the receive line.
   assumes a free running 16x receive clock from the bench. */
`timescale 1ns/1ps
module serial_terminal
(
	// clocks
	input  wire logic mclk,
	input  wire logic rx_clock_16x,
	// line into the receiver
	output logic      serial_line
);
	initial serial_line = 1'b1;

	// one bit spans 32 edges of the 16x clock
	task automatic put(input logic b);
		serial_line <= b;
		repeat (32) @(edge rx_clock_16x);
		@(posedge mclk);
	endtask

	// hi starts the frame while the 16x clock is high
	task automatic send(input logic [7:0] d, input int n, input logic np,
		input logic two, ev, bp, bs, hi);
		int i;
		if (hi)
			@(posedge rx_clock_16x);
		else
			@(negedge rx_clock_16x);
		@(posedge mclk);
		put(1'b0);
		for (i = 0; i < n; i++)
			put(d[i]);
		if (!np)
			put(^d ^ !ev ^ bp);
		if (two)
			put(1'b1);
		put(!bs);
		serial_line <= 1'b1;
	endtask

	// too short to survive start verification
	task automatic blip();
		serial_line <= 1'b0;
		repeat (8) @(edge rx_clock_16x);
		@(posedge mclk);
		serial_line <= 1'b1;
	endtask
endmodule

// ### bench/testbench.sv
/* self-checking bench for the serial transceiver.
   assumes the bound checker and the serial_terminal model. */
`timescale 1ns/1ps
module testbench;
	logic        mclk = 1'b0;
	logic        tx_clock_16x = 1'b0;
	logic        rx_clock_16x = 1'b0;
	logic        nrst, external_reset_in, control_load_strobe;
	logic        parity_sense_select, parity_disable, stop_count_select;
	logic        length_select_lo, length_select_hi, data_load_strobe;
	logic        rx_data_taken, serial_in, rx_char_ready, parity_fault;
	logic        frame_fault, overrun, tx_holding_empty, char_end;
	logic        serial_out, np, two, ev;
	logic [7:0]  tx_data, rx_data, d;
	logic [31:0] seed = 32'h0000e2d7;
	int          n, k, fails = 0, tests_run = 0;

	initial forever #5 mclk = ~mclk;
	// unrelated 16x rates
	initial forever #40 tx_clock_16x = ~tx_clock_16x;
	initial forever #43 rx_clock_16x = ~rx_clock_16x;

	async_serial_transceiver u_dut (.mclk, .nrst, .external_reset_in,
		.tx_clock_16x, .rx_clock_16x, .control_load_strobe,
		.parity_sense_select, .parity_disable, .stop_count_select,
		.length_select_lo, .length_select_hi, .data_load_strobe, .tx_data,
		.rx_data_taken, .rx_data, .rx_char_ready, .parity_fault,
		.frame_fault, .overrun, .tx_holding_empty, .char_end, .serial_in,
		.serial_out);
	serial_terminal u_term (.mclk, .rx_clock_16x, .serial_line(serial_in));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [7:0] mask(input logic [7:0] v);
		return v & (8'hff >> (8 - n));
	endfunction
	function automatic logic par(input logic [7:0] v, input logic e);
		return ^v ^ !e;
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// control goes in before the data, or on the same edge in frame test 9
	task automatic set_cfg(input logic [4:0] c);
		@(posedge mclk);
		{parity_sense_select, parity_disable, stop_count_select,
			length_select_hi, length_select_lo} <= c;
		control_load_strobe <= 1'b1;
		repeat (4) @(posedge mclk);
		control_load_strobe <= 1'b0;
		n = 5 + int'(c[1:0]);
		{ev, np, two} = c[4:2];
	endtask

	task automatic load(input logic [7:0] v);
		@(posedge mclk);
		tx_data <= v;
		data_load_strobe <= 1'b1;
		repeat (4) @(posedge mclk);
		data_load_strobe <= 1'b0;
	endtask

	task automatic tx_bit(input logic e);
		repeat (16) @(negedge tx_clock_16x);
		check(serial_out, e);
	endtask

	task automatic check_tx(input logic [7:0] v);
		int i;
		i = 0;
		while (serial_out !== 1'b0 && i < 3000)
		begin
			@(posedge mclk);
			i++;
		end
		repeat (8) @(negedge tx_clock_16x);
		check(serial_out, 1'b0);
		check(char_end, 1'b0);
		for (i = 0; i < n; i++)
			tx_bit(v[i]);
		if (!np)
			tx_bit(par(v, ev));
		if (two)
			tx_bit(1'b1);
		tx_bit(1'b1);
	endtask

	task automatic send_rx(input logic [7:0] v, input logic bp, bs);
		seed = xs(seed);
		u_term.send(v, n, np, two, ev, bp, bs, seed[0]);
	endtask

	task automatic check_rx(input logic [7:0] v, input logic pe, fe, ov);
		repeat (6) @(posedge mclk);
		check(rx_char_ready, 1'b1);
		check(rx_data, v);
		check(parity_fault, pe);
		check(frame_fault, fe);
		check(overrun, ov);
	endtask

	task automatic take();
		rx_data_taken <= 1'b1;
		repeat (4) @(posedge mclk);
		rx_data_taken <= 1'b0;
		repeat (8) @(posedge mclk);
		check(rx_char_ready, 1'b0);
	endtask

	initial
	begin
		#900000;
		fails++;
		stop_test();
	end

	initial
	begin
		{nrst, external_reset_in, control_load_strobe} = 3'b000;
		{parity_sense_select, parity_disable, stop_count_select} = 3'b000;
		{length_select_lo, length_select_hi, data_load_strobe} = 3'b000;
		rx_data_taken = 1'b0;
		tx_data = 8'h00;
		repeat (2) @(posedge mclk);
		check(serial_out, 1'b1);
		check(tx_holding_empty, 1'b1);
		check(char_end, 1'b1);
		check(rx_char_ready, 1'b0);
		@(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		for (k = 0; k < 10; k++)
		begin
			seed = xs(seed);
			d = seed[15:8];
			if (k == 9)
			begin
				// both strobes on one edge; full width keeps parity exact
				fork
					set_cfg({seed[4:2], 2'b11});
					load(d);
				join
			end
			else
			begin
				set_cfg(k < 4 ? {seed[4:2], k[1:0]} : seed[4:0]);
				d = mask(d);
				load(d);
			end
			check_tx(d);
			repeat (12) @(negedge tx_clock_16x);
			@(posedge mclk);
			check(char_end, 1'b1);
			send_rx(mask(~d), 1'b0, 1'b0);
			check_rx(mask(~d), 1'b0, 1'b0, 1'b0);
			take();
			$display("frame test %0d done", k);
		end
		for (k = 0; k < 4; k++)
		begin
			set_cfg({1'b1, k[0], k[1], 2'b11});
			send_rx(8'h5a, 1'b1, k[1]);
			check_rx(8'h5a, !k[0], k[1], 1'b0);
			take();
		end
		$display("fault test done");
		send_rx(8'h11, 1'b0, 1'b0);
		send_rx(8'h22, 1'b0, 1'b0);
		check_rx(8'h22, 1'b0, 1'b0, 1'b1);
		take();
		u_term.blip();
		repeat (600) @(posedge mclk);
		check(rx_char_ready, 1'b0);
		send_rx(8'h33, 1'b0, 1'b0);
		check_rx(8'h33, 1'b0, 1'b0, 1'b0);
		take();
		$display("overrun test done");
		load(8'ha5);
		repeat (20) @(posedge mclk);
		check(tx_holding_empty, 1'b1);
		load(8'h3c);
		repeat (4) @(posedge mclk);
		check(tx_holding_empty, 1'b0);
		check_tx(8'ha5);
		check_tx(8'h3c);
		$display("back to back test done");
		send_rx(8'h44, 1'b0, 1'b0);
		load(8'h0f);
		repeat (300) @(posedge mclk);
		external_reset_in <= 1'b1;
		repeat (6) @(posedge mclk);
		check(serial_out, 1'b1);
		check(tx_holding_empty, 1'b1);
		check(char_end, 1'b1);
		check(rx_char_ready, 1'b0);
		external_reset_in <= 1'b0;
		repeat (200) @(posedge mclk);
		$display("external reset test done");
		stop_test();
	end
endmodule
